// ===== common/ssp_pkg.sv
// Package of constants and types for the synchronous serial port mode controller.
`default_nettype none
package ssp_pkg;
	// Bus and register geometry.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CTRL_FIRST = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CTRL_SECOND = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_BAUD_RELOAD = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_INT_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h14;
	// Reset values.
	localparam logic [REG_W-1:0] RST_STATUS = 8'h00;
	localparam logic [REG_W-1:0] RST_CTRL_FIRST = 8'h00;
	localparam logic [REG_W-1:0] RST_CTRL_SECOND = 8'h00;
	localparam logic [REG_W-1:0] RST_BAUD_RELOAD = 8'h00;
	localparam logic [REG_W-1:0] RST_INT = 8'h00;
	// Field positions.
	localparam int ST_SMP = 7;
	localparam int ST_CKE = 6;
	localparam int ST_STOP = 4;
	localparam int ST_START = 3;
	localparam logic [REG_W-1:0] ST_WR_MASK = 8'hc0;
	localparam int C1_EN = 5;
	localparam int C1_CKP = 4;
	localparam int C1_MODE_HI = 3;
	localparam int C1_MODE_LO = 0;
	localparam int C2_FW_SCL = 1;
	localparam int C2_FW_SDA = 0;
	localparam int IRQ_START = 0;
	localparam int IRQ_STOP = 1;
	localparam int IRQ_BAD_MODE = 2;
	localparam logic [REG_W-1:0] IRQ_MASK_ALL = 8'h07;
	// Mode codes.
	localparam logic [3:0] M_SPI_DIV4 = 4'h0;
	localparam logic [3:0] M_SPI_DIV16 = 4'h1;
	localparam logic [3:0] M_SPI_DIV64 = 4'h2;
	localparam logic [3:0] M_SPI_TMR = 4'h3;
	localparam logic [3:0] M_SPI_SLV_SS = 4'h4;
	localparam logic [3:0] M_SPI_SLV_NOSS = 4'h5;
	localparam logic [3:0] M_I2C_SLV7 = 4'h6;
	localparam logic [3:0] M_I2C_SLV10 = 4'h7;
	localparam logic [3:0] M_I2C_MST = 4'h8;
	localparam logic [3:0] M_I2C_FW = 4'hb;
	localparam logic [3:0] M_I2C_SLV7_IRQ = 4'he;
	localparam logic [3:0] M_I2C_SLV10_IRQ = 4'hf;
	// Clock dividers: full serial clock period in core clocks, and the half period.
	localparam int CNT_W = 10;
	localparam int DIV4 = 4;
	localparam int DIV16 = 16;
	localparam int DIV64 = 64;
	localparam int I2C_BAUD_MULT = 4;
	localparam logic [CNT_W-1:0] HALF_DIV4 = CNT_W'(DIV4 / 2);
	localparam logic [CNT_W-1:0] HALF_DIV16 = CNT_W'(DIV16 / 2);
	localparam logic [CNT_W-1:0] HALF_DIV64 = CNT_W'(DIV64 / 2);
	localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
	// Decoded mode.
	typedef struct packed {
		logic spi_master;
		logic spi_slave;
		logic ss_used;
		logic i2c_master;
		logic i2c_fw;
		logic i2c_slave;
		logic addr10;
		logic edge_irq;
		logic reserved;
	} ssp_mode_t;
	// APB request as seen by the slave.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} ssp_apb_req_t;
endpackage
`default_nettype wire

// ===== rtl/ssp_mode_ctrl.sv
// Mode selection, clock source and status front end of the synchronous serial port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - one status and two control registers
// - low nibble of first control selects mode
// - codes 0-2 SPI master at core/4/16/64
// - code 3 SPI master at half timer rate
// - code 4 SPI slave, slave select honoured
// - code 5 SPI slave, select pin is free
// - code 8 I2C master, core/(4*(reload+1))
// - code 11 firmware I2C master, slave idle
// - codes 14,15 I2C slave plus start/stop interrupts
module ssp_mode_ctrl
	import ssp_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Clock sources and pins.
	input wire logic timer_pulse,
	input wire logic sck_i,
	input wire logic ss_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sck_o,
	output logic sck_oe,
	output logic scl_o,
	output logic scl_oe,
	output logic sda_o,
	output logic sda_oe,
	// Decoded mode and status towards the shift engine.
	output var ssp_mode_t mode,
	output logic slave_active,
	output logic ss_gpio_free,
	output logic slave_clk,
	// Interrupt.
	output logic irq
);

	// Decodes a mode code into role, clock source and options.
	function automatic ssp_mode_t decode_mode(input logic [3:0] code);
		ssp_mode_t m;
		m = '0;
		case (code)
			M_SPI_DIV4, M_SPI_DIV16, M_SPI_DIV64, M_SPI_TMR: begin
				m.spi_master = 1'b1;
			end
			M_SPI_SLV_SS: begin
				m.spi_slave = 1'b1;
				m.ss_used = 1'b1;
			end
			M_SPI_SLV_NOSS: begin
				m.spi_slave = 1'b1;
			end
			M_I2C_SLV7: begin
				m.i2c_slave = 1'b1;
			end
			M_I2C_SLV10: begin
				m.i2c_slave = 1'b1;
				m.addr10 = 1'b1;
			end
			M_I2C_MST: begin
				m.i2c_master = 1'b1;
			end
			M_I2C_FW: begin
				m.i2c_fw = 1'b1;
			end
			M_I2C_SLV7_IRQ: begin
				m.i2c_slave = 1'b1;
				m.edge_irq = 1'b1;
			end
			M_I2C_SLV10_IRQ: begin
				m.i2c_slave = 1'b1;
				m.addr10 = 1'b1;
				m.edge_irq = 1'b1;
			end
			default: begin
				m.reserved = 1'b1;
			end
		endcase
		return m;
	endfunction

	// Half period of the generated clock, in core clocks, for a mode.
	function automatic logic [CNT_W-1:0] half_period(input logic [3:0] code, input logic [REG_W-1:0] reload);
		logic [CNT_W-1:0] h;
		h = HALF_DIV4;
		case (code)
			M_SPI_DIV16: begin
				h = HALF_DIV16;
			end
			M_SPI_DIV64: begin
				h = HALF_DIV64;
			end
			M_I2C_MST: begin
				h = CNT_W'((I2C_BAUD_MULT / 2) * (32'(reload) + 32'd1));
			end
			default: begin
				h = HALF_DIV4;
			end
		endcase
		return h;
	endfunction

	ssp_apb_req_t req;
	logic [REG_W-1:0] status_q;
	logic [REG_W-1:0] ctrl_first_q;
	logic [REG_W-1:0] ctrl_second_q;
	logic [REG_W-1:0] baud_reload_q;
	logic [REG_W-1:0] int_status_q;
	logic [REG_W-1:0] int_mask_q;
	logic [CNT_W-1:0] div_cnt_q;
	logic gen_clk_q;
	logic sda_prev_q;
	logic [3:0] mode_code;
	logic port_en;
	ssp_mode_t mode_d;
	logic access;
	logic wr_en;
	logic rd_en;
	logic mapped;
	logic [REG_W-1:0] rd_val;
	logic start_seen;
	logic stop_seen;
	logic [REG_W-1:0] irq_events;
	logic bad_mode_write;
	ssp_mode_t wr_mode;

	// Bundle the bus request and decode the access phase.
	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
	assign access = req.psel & req.penable & pready;
	assign wr_en = access & req.pwrite & mapped;
	assign rd_en = access & ~req.pwrite;
	assign mode_code = ctrl_first_q[C1_MODE_HI:C1_MODE_LO];
	assign port_en = ctrl_first_q[C1_EN];
	assign mode_d = decode_mode(mode_code);

	// Address decode and read multiplexer; unmapped reads return zero.
	always_comb begin
		mapped = 1'b1;
		rd_val = '0;
		case (req.paddr)
			OFF_STATUS: begin
				rd_val = status_q;
			end
			OFF_CTRL_FIRST: begin
				rd_val = ctrl_first_q;
			end
			OFF_CTRL_SECOND: begin
				rd_val = ctrl_second_q;
			end
			OFF_BAUD_RELOAD: begin
				rd_val = baud_reload_q;
			end
			OFF_INT_STATUS: begin
				rd_val = int_status_q;
			end
			OFF_INT_MASK: begin
				rd_val = int_mask_q;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// One wait state: pready rises in the second access cycle, read data with it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= req.psel & req.penable & ~pready;
			pslverr <= req.psel & req.penable & ~pready & ~mapped;
			if (req.psel & req.penable & ~pready & ~req.pwrite) begin
				prdata <= DATA_W'(rd_val);
			end
		end
	end

	// Control registers written by software.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_first_q <= RST_CTRL_FIRST;
			ctrl_second_q <= RST_CTRL_SECOND;
			baud_reload_q <= RST_BAUD_RELOAD;
			int_mask_q <= RST_INT;
		end else if (wr_en) begin
			case (req.paddr)
				OFF_CTRL_FIRST: begin
					ctrl_first_q <= req.pwdata[REG_W-1:0];
				end
				OFF_CTRL_SECOND: begin
					ctrl_second_q <= req.pwdata[REG_W-1:0];
				end
				OFF_BAUD_RELOAD: begin
					baud_reload_q <= req.pwdata[REG_W-1:0];
				end
				OFF_INT_MASK: begin
					int_mask_q <= req.pwdata[REG_W-1:0] & IRQ_MASK_ALL;
				end
				default: begin
				end
			endcase
		end
	end

	// Start and stop on the bus: data changes while the clock line is high.
	assign start_seen = port_en & mode_d.i2c_slave & scl_i & sda_prev_q & ~sda_i;
	assign stop_seen = port_en & mode_d.i2c_slave & scl_i & ~sda_prev_q & sda_i;
	// Decode of the mode code being written, used to flag reserved codes.
	assign wr_mode = decode_mode(req.pwdata[C1_MODE_HI:C1_MODE_LO]);
	assign bad_mode_write = wr_en & (req.paddr == OFF_CTRL_FIRST) & wr_mode.reserved;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_prev_q <= 1'b1;
		end else begin
			sda_prev_q <= sda_i;
		end
	end

	// Status register: sample and edge bits writable, start and stop bits tracked.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q <= RST_STATUS;
		end else begin
			if (wr_en & (req.paddr == OFF_STATUS)) begin
				status_q[ST_SMP] <= req.pwdata[ST_SMP];
				status_q[ST_CKE] <= req.pwdata[ST_CKE];
			end
			if (!port_en) begin
				status_q[ST_START] <= 1'b0;
				status_q[ST_STOP] <= 1'b0;
			end else if (start_seen) begin
				status_q[ST_START] <= 1'b1;
				status_q[ST_STOP] <= 1'b0;
			end else if (stop_seen) begin
				status_q[ST_START] <= 1'b0;
				status_q[ST_STOP] <= 1'b1;
			end
		end
	end

	// Sticky interrupt flags; a new event wins over a write-one clear.
	assign irq_events = REG_W'({bad_mode_write, stop_seen & mode_d.edge_irq, start_seen & mode_d.edge_irq});
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status_q <= RST_INT;
		end else if (wr_en & (req.paddr == OFF_INT_STATUS)) begin
			int_status_q <= (int_status_q & ~req.pwdata[REG_W-1:0]) | irq_events;
		end else begin
			int_status_q <= int_status_q | irq_events;
		end
	end

	// Level interrupt from unmasked flags.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status_q & int_mask_q);
		end
	end

	// Clock generator: counter halves for dividers, timer pulses toggle directly.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_q <= CNT_ONE;
			gen_clk_q <= 1'b0;
		end else if (!port_en || !(mode_d.spi_master || mode_d.i2c_master)) begin
			div_cnt_q <= CNT_ONE;
			gen_clk_q <= 1'b0;
		end else if (mode_code == M_SPI_TMR) begin
			if (timer_pulse) begin
				gen_clk_q <= ~gen_clk_q;
			end
		end else if (div_cnt_q >= half_period(mode_code, baud_reload_q)) begin
			div_cnt_q <= CNT_ONE;
			gen_clk_q <= ~gen_clk_q;
		end else begin
			div_cnt_q <= div_cnt_q + CNT_ONE;
		end
	end

	// Serial clock pin: driven in SPI master, idle level from the polarity bit.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sck_o <= 1'b0;
			sck_oe <= 1'b0;
		end else begin
			sck_o <= gen_clk_q ^ ctrl_first_q[C1_CKP];
			sck_oe <= port_en & mode_d.spi_master;
		end
	end

	// Open-drain bus lines: only ever pull low; firmware mode drives from the second control.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_o <= 1'b0;
			scl_oe <= 1'b0;
			sda_o <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			if (port_en & mode_d.i2c_master) begin
				scl_oe <= ~gen_clk_q;
				sda_oe <= 1'b0;
			end else if (port_en & mode_d.i2c_fw) begin
				scl_oe <= ~ctrl_second_q[C2_FW_SCL];
				sda_oe <= ~ctrl_second_q[C2_FW_SDA];
			end else begin
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
			end
		end
	end

	// Mode and slave gating towards the shift engine.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= '0;
			slave_active <= 1'b0;
			ss_gpio_free <= 1'b0;
			slave_clk <= 1'b0;
		end else begin
			mode <= port_en ? mode_d : '0;
			slave_active <= port_en & ((mode_d.spi_slave & (~mode_d.ss_used | ~ss_n_i)) | mode_d.i2c_slave);
			ss_gpio_free <= ~(port_en & mode_d.ss_used);
			slave_clk <= port_en & mode_d.spi_slave & sck_i;
		end
	end

endmodule
`default_nettype wire

// ===== dv/ssp_peer.sv
// Bus peer that pulls the open-drain lines and makes start and stop conditions.
`timescale 1ns/1ps
`default_nettype none
module ssp_peer (
	// Clock and commands.
	input wire logic pclk,
	input wire logic go_start,
	input wire logic go_stop,
	// Open-drain lines.
	input wire logic scl_oe,
	input wire logic sda_oe,
	output logic scl_i,
	output logic sda_i
);
	logic sda_q = 1'b1;
	// Pull-ups hold each line high unless some party pulls it low.
	assign scl_i = !scl_oe;
	assign sda_i = !sda_oe && sda_q;
	// The data line falls on a start command and rises on a stop command, whatever the clock line does.
	always_ff @(posedge pclk) begin
		if (go_start) begin
			sda_q <= 1'b0;
		end else if (go_stop) begin
			sda_q <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== dv/ssp_mode_ctrl_chk.sv
// Checker of the serial port mode front end.
`timescale 1ns/1ps
`default_nettype none
module ssp_chk
	import ssp_pkg::*;
(
	// Clock, reset and bus.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and decoded state.
	input wire logic timer_pulse,
	input wire logic ss_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sck_o,
	input wire logic sck_i,
	input wire logic sck_oe,
	input wire logic scl_o,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic slave_clk,
	input wire logic scl_oe,
	input wire ssp_mode_t mode,
	input wire logic slave_active,
	input wire logic ss_gpio_free,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] ctl_q;
	logic [7:0] rl_q;
	logic [7:0] mk_q;
	logic [7:0] c2_q;
	logic wr;
	assign wr = psel && penable && pready && pwrite;
	// Shadow copies of the registers that steer the checks.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_q <= 8'h00;
			rl_q <= 8'h00;
			mk_q <= 8'h00;
			c2_q <= 8'h00;
		end else if (wr) begin
			if (paddr == OFF_CTRL_SECOND) c2_q <= pwdata[7:0];
			if (paddr == OFF_CTRL_FIRST) ctl_q <= pwdata[7:0];
			if (paddr == OFF_BAUD_RELOAD) rl_q <= pwdata[7:0];
			if (paddr == OFF_INT_MASK) mk_q <= pwdata[7:0];
		end
	end
	property p_rdy; psel && !penable |=> !pready ##1 pready; endproperty
	a_rdy: assert property (p_rdy) else $error("bad wait state");
	property p_err; pready |-> pslverr == !(paddr <= OFF_INT_MASK && paddr[1:0] == 2'b00); endproperty
	a_err: assert property (p_err) else $error("bad slave error");
	property p_div4; ctl_q == 8'h20 && $past(ctl_q, 6) == 8'h20 |-> sck_o != $past(sck_o, 2); endproperty
	a_div4: assert property (p_div4) else $error("bad clock by 4");
	property p_div16; ctl_q == 8'h21 && $past(ctl_q, 12) == 8'h21 |-> sck_o != $past(sck_o, 8); endproperty
	a_div16: assert property (p_div16) else $error("bad clock by 16");
	property p_div64; ctl_q == 8'h22 && $past(ctl_q, 36) == 8'h22 |-> sck_o != $past(sck_o, 32); endproperty
	a_div64: assert property (p_div64) else $error("bad clock by 64");
	property p_tmr; ctl_q == 8'h23 && $past(ctl_q, 4) == 8'h23 |-> $changed(sck_o) == $past(timer_pulse, 2); endproperty
	a_tmr: assert property (p_tmr) else $error("bad timer clock");
	property p_ss; ctl_q == 8'h24 && $past(ctl_q, 2) == 8'h24 |-> slave_active == !$past(ss_n_i) && !ss_gpio_free;
	endproperty
	a_ss: assert property (p_ss) else $error("select ignored");
	property p_noss; ctl_q == 8'h25 && $past(ctl_q, 2) == 8'h25 |-> slave_active && ss_gpio_free; endproperty
	a_noss: assert property (p_noss) else $error("select not free");
	property p_slv; ctl_q[5] && ctl_q[2:1] == 2'b11 && $past(ctl_q, 2) == ctl_q
		|-> mode.i2c_slave && mode.addr10 == ctl_q[0] && mode.edge_irq == ctl_q[3] && slave_active; endproperty
	a_slv: assert property (p_slv) else $error("bad bus slave mode");
	property p_mst; ctl_q == 8'h28 && rl_q == 8'h02 && $past(ctl_q, 10) == 8'h28 |-> scl_oe != $past(scl_oe, 6);
	endproperty
	a_mst: assert property (p_mst) else $error("bad bus master clock");
	property p_fw; ctl_q == 8'h2b && $past(ctl_q, 2) == 8'h2b |-> mode.i2c_fw && !slave_active; endproperty
	a_fw: assert property (p_fw) else $error("slave not idle");
	property p_irq; ctl_q[5] && ctl_q[3:1] == 3'b111 && mk_q[0] && scl_i && $fell(sda_i) |-> ##[1:2] irq; endproperty
	a_irq: assert property (p_irq) else $error("no start interrupt");
	property p_sckoe; sck_oe == ($past(ctl_q[5]) && $past(ctl_q[3:2]) == 2'b00); endproperty
	a_sckoe: assert property (p_sckoe) else $error("bad clock pin enable");
	property p_sclk; slave_clk == ($past(ctl_q[5]) && $past(ctl_q[3:1]) == 3'b010 && $past(sck_i)); endproperty
	a_sclk: assert property (p_sclk) else $error("bad slave clock");
	property p_od; !scl_o && !sda_o; endproperty
	a_od: assert property (p_od) else $error("bus line driven high");
	property p_fwpin; ctl_q == 8'h2b && $past(ctl_q, 2) == 8'h2b && $past(c2_q) == c2_q
		|-> scl_oe == !c2_q[1] && sda_oe == !c2_q[0]; endproperty
	a_fwpin: assert property (p_fwpin) else $error("bad firmware line levels");
endmodule
`default_nettype wire

// ===== dv/ssp_mode_ctrl_test.sv
// Self-checking bench of the serial port mode front end.
`timescale 1ns/1ps
`default_nettype none
module ssp_mode_ctrl_test;
	import ssp_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, timer_pulse = 0;
	logic sck_i = 0, ss_n_i = 1, go_start = 0, go_stop = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0, prdata;
	logic pready, pslverr, scl_i, sda_i, sck_o, sck_oe, scl_o, scl_oe, sda_o, sda_oe, slave_active;
	logic ss_gpio_free, slave_clk, irq;
	ssp_mode_t mode;
	logic [32:0] q[$];
	logic [32:0] e;
	logic [31:0] lf = 32'h9482, r, rv;
	logic [3:0] codes[12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hb, 4'he, 4'hf};
	int n_fail = 0, comparisons = 0, cyc = 0;
	ssp_mode_ctrl dut_u(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.timer_pulse, .sck_i, .ss_n_i, .scl_i, .sda_i, .sck_o, .sck_oe, .scl_o, .scl_oe, .sda_o, .sda_oe,
		.mode, .slave_active, .ss_gpio_free, .slave_clk, .irq);
	ssp_peer peer_u(.pclk, .go_start, .go_stop, .scl_oe, .sda_oe, .scl_i, .sda_i);
	function automatic logic [31:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction
	task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// One bus transfer; the expected error flag and read word go to the queue.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
		q.push_back(x);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic pin(input logic x);
		repeat (2) @(posedge pclk);
		cmp({32'h0, irq}, {32'h0, x});
	endtask
	task automatic ev(input logic s);
		go_start <= s;
		go_stop <= !s;
		@(posedge pclk);
		go_start <= 1'b0;
		go_stop <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	// Clock at 40 MHz.
	initial begin
		forever #12.5 pclk = ~pclk;
	end
	// Answers are compared with the oldest note.
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			e = q.pop_front();
			cmp({pslverr, pwrite ? 32'h0 : prdata}, e);
		end
	end
	// Random select, timer pulses and external clock.
	always @(posedge pclk) begin
		r = rnd();
		ss_n_i <= r[0];
		timer_pulse <= r[1] & r[2];
		sck_i <= r[3];
	end
	// Cut a hang short.
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_fail++;
			conclude();
		end
	end
	// Main sequence.
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int a = 0; a < 28; a += 4) apb(0, a[7:0], 0, {a == 24, 32'h0});
		apb(1, OFF_STATUS, 32'hff, 33'h0);
		apb(0, OFF_STATUS, 0, 33'hc0);
		apb(1, OFF_STATUS, 0, 33'h0);
		rv = rnd();
		apb(1, OFF_BAUD_RELOAD, rv, 33'h0);
		apb(0, OFF_BAUD_RELOAD, 0, {25'h0, rv[7:0]});
		apb(1, OFF_BAUD_RELOAD, 32'h2, 33'h0);
		apb(1, OFF_CTRL_FIRST, 32'h2c, 33'h0);
		apb(0, OFF_INT_STATUS, 0, 33'h4);
		pin(1'b0);
		apb(1, OFF_INT_MASK, 32'h7, 33'h0);
		pin(1'b1);
		apb(1, OFF_INT_STATUS, 32'h4, 33'h0);
		pin(1'b0);
		apb(1, OFF_INT_MASK, 32'h3, 33'h0);
		apb(1, OFF_CTRL_SECOND, 32'h2, 33'h0);
		apb(0, OFF_CTRL_SECOND, 0, 33'h2);
		foreach (codes[i]) begin
			apb(1, OFF_CTRL_FIRST, {28'h2, codes[i]}, 33'h0);
			apb(0, OFF_CTRL_FIRST, 0, {29'h2, codes[i]});
			repeat (70) @(posedge pclk);
			if (codes[i][2:1] == 2'b11) begin
				apb(1, OFF_INT_STATUS, 32'h3, 33'h0);
				ev(1'b1);
				apb(0, OFF_STATUS, 0, 33'h08);
				pin(codes[i][3]);
				apb(1, OFF_INT_STATUS, 32'h3, 33'h0);
				ev(1'b0);
				apb(0, OFF_STATUS, 0, 33'h10);
				pin(codes[i][3]);
				apb(1, OFF_INT_STATUS, 32'h3, 33'h0);
			end
		end
		apb(1, OFF_CTRL_FIRST, 32'h0f, 33'h0);
		apb(0, OFF_STATUS, 0, 33'h0);
		cmp({24'h0, mode}, 33'h0);
		conclude();
	end
endmodule
bind ssp_mode_ctrl ssp_chk chk_u(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.timer_pulse, .ss_n_i, .scl_i, .sda_i, .sck_o, .sck_i, .sck_oe, .scl_o, .sda_o, .sda_oe, .slave_clk,
	.scl_oe, .mode, .slave_active, .ss_gpio_free, .irq);
`default_nettype wire
